/* File: rtl/owp_pkg.sv */
package owp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths and counts
	localparam int CODE_W     = 6;
	localparam int NUM_TAPS   = 64;
	localparam int FUSE_COUNT = 8;

	////////////////////////////////////////////////////////////////////////////
	// Codes, address and field positions
	localparam logic [5:0] WIPER_MIDSCALE  = 6'h20;
	localparam logic [5:0] SLAVE_ADDR_HI   = 6'h16;
	localparam int         ADDR_SEL_BIT    = 1;
	localparam int         ADDR_RW_BIT     = 0;
	localparam int         INSTR_PROG_BIT  = 7;
	localparam logic [1:0] VAL_READY       = 2'h0;
	localparam logic [1:0] VAL_SETUP_FAULT = 2'h1;
	localparam logic [1:0] VAL_FATAL       = 2'h2;
	localparam logic [1:0] VAL_DONE        = 2'h3;
	localparam logic [2:0] FUSE_TEST_IDX   = 3'h6;
	localparam logic [2:0] FUSE_LOCK_IDX   = 3'h7;
	localparam logic [2:0] LAST_DATA_IDX   = 3'h5;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int SEQ_TICK_NS      = 1000;
	localparam int SEQ_TICK_CYCLES  = (SEQ_TICK_NS * 1000) / CLK_PERIOD_PS;
	localparam int BOOT_WAIT_CYCLES = 6;

	////////////////////////////////////////////////////////////////////////////
	// State types
	typedef enum logic [2:0] {
		BS_IDLE, BS_ADDR, BS_RX, BS_ACK1, BS_ACK2, BS_TX, BS_MACK, BS_WAIT
	} owp_bus_state_t;

	typedef enum logic [2:0] {
		SQ_IDLE, SQ_TEST, SQ_TCHK, SQ_DATA, SQ_CMP, SQ_LOCK
	} owp_seq_state_t;

	// One-hot tap selection from a wiper code
	function automatic logic [NUM_TAPS-1:0] owp_tap_decode(input logic [CODE_W-1:0] code);
		owp_tap_decode = {{(NUM_TAPS-1){1'b0}}, 1'b1} << code;
	endfunction : owp_tap_decode

endpackage : owp_pkg

/* File: rtl/owp_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface owp_seq_if;
	import owp_pkg::*;
	logic              start;
	logic [CODE_W-1:0] code;
	logic              locked_preset;
	logic              busy;
	logic [1:0]        validation;

	modport ctl (output start, code, locked_preset, input busy, validation);
	modport seq (input start, code, locked_preset, output busy, validation);
endinterface : owp_seq_if

`default_nettype wire

/* File: rtl/owp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module owp_pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Pins and filtered result
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] ff1, ff2, ff3;
	logic [WIDTH-1:0] next_sync;

	// A bit changes only once the second and third stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_sync[i] = (ff2[i] == ff3[i]) ? ff3[i] : sync_out[i];
		end
	end

	// Three stages; the first feeds only the second
	always_ff @(posedge clk) begin
		if (srst) begin
			ff1      <= '1;
			ff2      <= '1;
			ff3      <= '1;
			sync_out <= '1;
		end else begin
			ff1      <= async_in;
			ff2      <= ff1;
			ff3      <= ff2;
			sync_out <= next_sync;
		end
	end
endmodule : owp_pin_sync

`default_nettype wire

/* File: rtl/owp_fuse_seq.sv */
`timescale 1ns/1ps
`default_nettype none

module owp_fuse_seq
	import owp_pkg::*;
#(
	parameter int TICK_CYCLES = SEQ_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// Control from the bus side
	owp_seq_if.seq                     sq,
	// Fuse array
	input  wire logic [FUSE_COUNT-1:0] fuse_state,
	output logic                       fuse_blow,
	output logic      [2:0]            fuse_index,
	output logic                       seq_clk_en
);
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	owp_seq_state_t    st, next_st;
	logic [15:0]       tick_cnt, next_tick_cnt;
	logic [2:0]        bit_idx, next_bit_idx;
	logic [CODE_W-1:0] code_q, next_code;
	logic [1:0]        validation, next_validation;
	logic              next_blow, next_clk_en;
	logic [2:0]        next_index;
	logic              tick;

	assign tick          = seq_clk_en && (tick_cnt == TICK_LAST);
	assign sq.busy       = seq_clk_en;
	assign sq.validation = validation;

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: internal clock runs only while programming
	always_comb begin
		next_st         = st;
		next_bit_idx    = bit_idx;
		next_code       = code_q;
		next_validation = validation;
		next_clk_en     = seq_clk_en;
		next_blow       = 1'b0;
		next_index      = fuse_index;
		next_tick_cnt   = (seq_clk_en && !tick) ? tick_cnt + 16'h0001 : 16'h0000;
		case (st)
			SQ_IDLE: begin
				if (sq.start && !sq.locked_preset && validation != VAL_DONE) begin
					next_st     = SQ_TEST;
					next_code   = sq.code;
					next_clk_en = 1'b1; // R5
				end
			end
			SQ_TEST: begin
				if (tick) begin
					next_blow  = 1'b1; // R6
					next_index = FUSE_TEST_IDX;
					next_st    = SQ_TCHK;
				end
			end
			SQ_TCHK: begin
				if (tick) begin
					if (fuse_state[FUSE_TEST_IDX]) begin
						next_st      = SQ_DATA;
						next_bit_idx = 3'h0;
					end else begin
						next_validation = VAL_SETUP_FAULT; // R6 R16
						next_clk_en     = 1'b0;
						next_st         = SQ_IDLE;
					end
				end
			end
			SQ_DATA: begin
				if (tick) begin
					next_blow    = code_q[bit_idx]; // R7 R12
					next_index   = bit_idx;
					next_bit_idx = bit_idx + 3'h1;
					if (bit_idx == LAST_DATA_IDX) begin
						next_st = SQ_CMP;
					end
				end
			end
			SQ_CMP: begin
				if (tick) begin
					if (fuse_state[CODE_W-1:0] == code_q) begin
						next_st = SQ_LOCK;
					end else begin
						next_validation = VAL_FATAL; // R8 R9
						next_clk_en     = 1'b0;
						next_st         = SQ_IDLE;
					end
				end
			end
			SQ_LOCK: begin
				if (tick) begin
					next_blow       = 1'b1; // R10
					next_index      = FUSE_LOCK_IDX;
					next_validation = VAL_DONE;
					next_clk_en     = 1'b0;
					next_st         = SQ_IDLE;
				end
			end
			default: next_st = SQ_IDLE;
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk) begin
		if (srst) begin
			st         <= SQ_IDLE;
			tick_cnt   <= 16'h0000;
			bit_idx    <= 3'h0;
			code_q     <= 6'h00;
			validation <= VAL_READY; // R15
			seq_clk_en <= 1'b0;
			fuse_blow  <= 1'b0;
			fuse_index <= 3'h0;
		end else begin
			st         <= next_st;
			tick_cnt   <= next_tick_cnt;
			bit_idx    <= next_bit_idx;
			code_q     <= next_code;
			validation <= next_validation;
			seq_clk_en <= next_clk_en;
			fuse_blow  <= next_blow;
			fuse_index <= next_index;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	seq_clock_start_a: assert property ( // R5
		(st == SQ_IDLE && sq.start && !sq.locked_preset && validation != VAL_DONE)
		|=> seq_clk_en && st == SQ_TEST)
		else $error("sequencer clock not started on program request");

	test_fault_a: assert property ( // R6
		(st == SQ_TCHK && tick && !fuse_state[FUSE_TEST_IDX])
		|=> validation == VAL_SETUP_FAULT && !seq_clk_en && st == SQ_IDLE)
		else $error("test fuse failure not reported");

	data_fuse_a: assert property ( // R7
		(st == SQ_DATA && tick)
		|=> fuse_index == $past(bit_idx) && fuse_blow == $past(code_q[bit_idx]))
		else $error("data fuse step wrong");

	mismatch_fatal_a: assert property ( // R8
		(st == SQ_CMP && tick && fuse_state[CODE_W-1:0] != code_q)
		|=> validation == VAL_FATAL && st == SQ_IDLE)
		else $error("fuse mismatch not fatal");

	retry_after_fatal_a: assert property ( // R9
		(st == SQ_IDLE && validation == VAL_FATAL && sq.start && !sq.locked_preset)
		|=> st == SQ_TEST)
		else $error("retry refused after fatal error");

	lock_blow_a: assert property ( // R10
		(st == SQ_CMP && tick && fuse_state[CODE_W-1:0] == code_q)
		|=> st == SQ_LOCK ##[1:300] (fuse_blow && fuse_index == FUSE_LOCK_IDX
		&& validation == VAL_DONE))
		else $error("lock fuse not blown after match");

	setup_only_a: assert property ( // R16
		($changed(validation) && validation == VAL_SETUP_FAULT)
		|-> $past(st) == SQ_TCHK)
		else $error("setup fault from wrong step");

	validation_hold_a: assert property ( // R15
		(st != SQ_TCHK && st != SQ_CMP && st != SQ_LOCK)
		|=> validation == $past(validation))
		else $error("validation changed outside a check step");
endmodule : owp_fuse_seq

`default_nettype wire

/* File: rtl/owp_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Power-on wiper code is midscale 32.
// R2: Write: address, instruction, data byte, acks.
// R3: Read: address then validation bits plus code.
// R4: Program bit one starts fuse programming.
// R5: Program request enables internal sequencer clock.
// R6: Failed test fuse stops, reports 01.
// R7: Six data fuses, one per tick.
// R8: Fuse mismatch reports 10 and stops.
// R9: After fatal error, programming may retry.
// R10: Match blows lock fuse, reports 11.
// R11: Locked part loads wiper from fuses.
// R12: Six data, one test, one lock fuse.
// R13: Code decodes to one-hot of 64 taps.
// R14: Each code step moves one tap up.
// R15: Validation reads 00 before any attempt.
// R16: Code 01 only for test fuse failure.
// R17: Address is 010110, select bit, direction.
// R18: Matching device acks on ninth pulse.
// R19: Select pin sets seventh address bit.
// R20: Unlocked write loads code after data byte.
// R21: Locked part acks writes, ignores them.
module owp_top
	import owp_pkg::*;
#(
	parameter int TICK_CYCLES = SEQ_TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// Two-wire bus pins
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	input  wire logic                  bus_address_select_pin,
	// Fuse array
	input  wire logic [FUSE_COUNT-1:0] fuse_state,
	output logic                       fuse_blow,
	output logic      [2:0]            fuse_index,
	output logic                       seq_clk_en,
	// Wiper and status
	output logic      [CODE_W-1:0]     resistor_ladder_setting,
	output logic      [NUM_TAPS-1:0]   tap_select,
	output logic                       validation_bit_high,
	output logic                       validation_bit_low,
	output logic                       part_locked
);
	owp_seq_if sq ();

	logic [2:0]            pins_sync;
	logic [FUSE_COUNT-1:0] fuse_sync;
	logic                  scl, sda, scl_q, sda_q;
	logic                  scl_rise, scl_fall, bus_start, bus_stop;

	////////////////////////////////////////////////////////////////////////////
	// Pin and fuse synchronisers
	owp_pin_sync #(.WIDTH(3)) u_pin_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in ({bus_address_select_pin, scl_in, sda_in}),
		.sync_out (pins_sync)
	);

	owp_pin_sync #(.WIDTH(FUSE_COUNT)) u_fuse_sync (
		.clk      (clk),
		.srst     (srst),
		.async_in (fuse_state),
		.sync_out (fuse_sync)
	);

	owp_fuse_seq #(.TICK_CYCLES(TICK_CYCLES)) u_seq (
		.clk        (clk),
		.srst       (srst),
		.sq         (sq.seq),
		.fuse_state (fuse_sync),
		.fuse_blow  (fuse_blow),
		.fuse_index (fuse_index),
		.seq_clk_en (seq_clk_en)
	);

	assign scl       = pins_sync[1];
	assign sda       = pins_sync[0];
	assign scl_rise  = scl && !scl_q;
	assign scl_fall  = !scl && scl_q;
	assign bus_start = scl && scl_q && sda_q && !sda;
	assign bus_stop  = scl && scl_q && !sda_q && sda;

	////////////////////////////////////////////////////////////////////////////
	// Power-on: wait for fuse readings, then pick preset or fused code
	logic [2:0]        boot_cnt, next_boot_cnt;
	logic              booted, next_booted;
	logic              locked_boot, next_locked_boot;
	logic              locked_now;
	logic [1:0]        val_now;

	assign val_now          = locked_boot ? VAL_DONE : sq.validation;
	assign locked_now       = (val_now == VAL_DONE);
	assign sq.locked_preset = locked_boot;

	always_comb begin
		next_boot_cnt    = boot_cnt;
		next_booted      = booted;
		next_locked_boot = locked_boot;
		if (!booted) begin
			next_boot_cnt = boot_cnt + 3'h1;
			if (boot_cnt == 3'(BOOT_WAIT_CYCLES - 1)) begin
				next_booted      = 1'b1;
				next_locked_boot = fuse_sync[FUSE_LOCK_IDX]; // R11
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			boot_cnt    <= 3'h0;
			booted      <= 1'b0;
			locked_boot <= 1'b0;
		end else begin
			boot_cnt    <= next_boot_cnt;
			booted      <= next_booted;
			locked_boot <= next_locked_boot;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus slave and wiper register
	owp_bus_state_t    bst, next_bst;
	logic [2:0]        bit_cnt, next_bit_cnt;
	logic [7:0]        shreg, next_shreg;
	logic [7:0]        rx_byte;
	logic [1:0]        byte_idx, next_byte_idx;
	logic              rd, next_rd, prog, next_prog;
	logic              next_sda_oe, next_start;
	logic [CODE_W-1:0] wiper, next_wiper;
	logic              start_q;

	assign rx_byte = {shreg[6:0], sda};
	assign sq.start = start_q;
	assign sq.code  = wiper;

	always_comb begin
		next_bst      = bst;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_byte_idx = byte_idx;
		next_rd       = rd;
		next_prog     = prog;
		next_sda_oe   = sda_oe;
		next_start    = 1'b0;
		next_wiper    = wiper;
		if (!booted) begin
			next_wiper = next_locked_boot ? fuse_sync[CODE_W-1:0] : WIPER_MIDSCALE; // R1 R11
		end
		if (bus_start) begin
			next_bst      = BS_ADDR;
			next_bit_cnt  = 3'h0;
			next_byte_idx = 2'h0;
			next_sda_oe   = 1'b0;
		end else if (bus_stop) begin
			next_bst    = BS_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (bst)
				BS_ADDR: begin
					if (scl_rise) begin
						next_shreg   = rx_byte;
						next_bit_cnt = bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							if (rx_byte[7:2] == SLAVE_ADDR_HI // R17
								&& rx_byte[ADDR_SEL_BIT] == pins_sync[2]) begin // R19
								next_rd  = rx_byte[ADDR_RW_BIT];
								next_bst = BS_ACK1;
							end else begin
								next_bst = BS_IDLE;
							end
						end
					end
				end
				BS_RX: begin
					if (scl_rise) begin
						next_shreg   = rx_byte;
						next_bit_cnt = bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							next_bst = BS_ACK1;
							if (byte_idx == 2'h1) begin
								next_prog = rx_byte[INSTR_PROG_BIT]; // R2
							end else if (!locked_now) begin // R21
								next_wiper = rx_byte[CODE_W-1:0]; // R20
								next_start = prog && !sq.busy; // R4
							end
						end
					end
				end
				BS_ACK1: begin
					if (scl_fall) begin
						next_sda_oe = 1'b1; // R18
						next_bst    = BS_ACK2;
					end
				end
				BS_ACK2: begin
					if (scl_fall) begin
						next_bit_cnt = 3'h0;
						if (byte_idx == 2'h0 && rd) begin
							next_shreg  = {val_now, wiper}; // R3
							next_sda_oe = !val_now[1];
							next_bst    = BS_TX;
						end else if (byte_idx == 2'h2) begin
							next_sda_oe = 1'b0;
							next_bst    = BS_WAIT;
						end else begin
							next_sda_oe   = 1'b0;
							next_byte_idx = byte_idx + 2'h1;
							next_bst      = BS_RX;
						end
					end
				end
				BS_TX: begin
					if (scl_fall) begin
						next_bit_cnt = bit_cnt + 3'h1;
						next_shreg   = {shreg[6:0], 1'b0};
						if (bit_cnt == 3'h7) begin
							next_sda_oe = 1'b0;
							next_bst    = BS_MACK;
						end else begin
							next_sda_oe = !shreg[6];
						end
					end
				end
				BS_MACK: begin
					if (scl_rise) begin
						next_bst = BS_WAIT;
					end
				end
				default: next_bst = bst;
			endcase
		end
	end

	// Bus and wiper registers
	always_ff @(posedge clk) begin
		if (srst) begin
			bst      <= BS_IDLE;
			bit_cnt  <= 3'h0;
			shreg    <= 8'h00;
			byte_idx <= 2'h0;
			rd       <= 1'b0;
			prog     <= 1'b0;
			sda_oe   <= 1'b0;
			start_q  <= 1'b0;
			wiper    <= WIPER_MIDSCALE; // R1
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			bst      <= next_bst;
			bit_cnt  <= next_bit_cnt;
			shreg    <= next_shreg;
			byte_idx <= next_byte_idx;
			rd       <= next_rd;
			prog     <= next_prog;
			sda_oe   <= next_sda_oe;
			start_q  <= next_start;
			wiper    <= next_wiper;
			scl_q    <= scl;
			sda_q    <= sda;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	logic [NUM_TAPS-1:0] next_tap;

	always_comb begin
		next_tap = owp_tap_decode(wiper); // R13 R14
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sda_out                 <= 1'b0;
			resistor_ladder_setting <= WIPER_MIDSCALE;
			tap_select              <= owp_tap_decode(WIPER_MIDSCALE);
			validation_bit_high     <= 1'b0;
			validation_bit_low      <= 1'b0;
			part_locked             <= 1'b0;
		end else begin
			sda_out                 <= 1'b0;
			resistor_ladder_setting <= wiper;
			tap_select              <= next_tap;
			validation_bit_high     <= val_now[1];
			validation_bit_low      <= val_now[0];
			part_locked             <= locked_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	midscale_preset_a: assert property ( // R1
		(!booted && !next_locked_boot) |=> wiper == WIPER_MIDSCALE)
		else $error("wiper not midscale before lock");

	fused_load_a: assert property ( // R11
		(!booted && next_booted && fuse_sync[FUSE_LOCK_IDX])
		|=> locked_boot && wiper == $past(fuse_sync[CODE_W-1:0]))
		else $error("locked part did not load fused code");

	tap_onehot_a: assert property ( // R13
		$onehot(tap_select) && tap_select[resistor_ladder_setting])
		else $error("tap selection not one-hot on code");

	tap_step_a: assert property ( // R14
		(wiper == $past(wiper) + 6'h01 && wiper != 6'h00)
		|=> ##1 tap_select == ($past(tap_select, 2) << 1))
		else $error("tap did not step up with code");

	addr_ack_a: assert property ( // R18
		(bst == BS_ACK1 && scl_fall) |=> sda_oe && bst == BS_ACK2)
		else $error("no acknowledge after match");

	addr_mismatch_a: assert property ( // R17
		(bst == BS_ADDR && scl_rise && bit_cnt == 3'h7 && !bus_start && !bus_stop
		&& rx_byte[7:2] != SLAVE_ADDR_HI) |=> bst == BS_IDLE && !sda_oe)
		else $error("foreign address answered");

	locked_write_a: assert property ( // R21
		(locked_now && booted && bst == BS_RX && byte_idx == 2'h2)
		|=> wiper == $past(wiper) && !start_q)
		else $error("locked part changed on write");

	program_start_a: assert property ( // R4
		(bst == BS_RX && byte_idx == 2'h2 && scl_rise && bit_cnt == 3'h7
		&& !bus_start && !bus_stop && prog && !locked_now && !sq.busy)
		|=> start_q ##1 seq_clk_en)
		else $error("program bit did not start sequencer");
endmodule : owp_top

`default_nettype wire

/* File: sim/owp_master.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-wire bus master model; data is open drain, clock idles high
module owp_master
	import owp_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Bus lines
	output logic      scl,
	output logic      sda_pull,
	input  wire logic sda
);
	logic r;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	////////////////////////////////////////
	// Wait a number of system clocks
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w

	// Data moves mid low phase so it never looks like start or stop
	task automatic bit_x(input logic b);
		w(5);
		sda_pull = ~b;
		w(5);
		scl = 1'b1;
		w(10);
		r = sda;
		scl = 1'b0;
	endtask : bit_x

	// Byte MSB first, then the ninth pulse; ack high when the line was pulled
	task automatic byte_x(input logic [7:0] b, input logic mack, output logic [7:0] d,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_x(b[i]);
			d[i] = r;
		end
		bit_x(~mack);
		ack = ~r;
	endtask : byte_x

	// Data falls while clock is high
	task automatic start_x;
		sda_pull = 1'b1;
		w(10);
		scl = 1'b0;
	endtask : start_x

	// Data rises while clock is high, then bus free time
	task automatic stop_x;
		w(5);
		sda_pull = 1'b1;
		w(5);
		scl = 1'b1;
		w(10);
		sda_pull = 1'b0;
		w(20);
	endtask : stop_x

	////////////////////////////////////////
	// Address, instruction, data, each acked by the device
	task automatic write_xfer(input logic [7:0] a, ins, dat, output logic [2:0] acks);
		logic [7:0] d;
		start_x;
		byte_x(a, 1'b0, d, acks[2]);
		byte_x(ins, 1'b0, d, acks[1]);
		byte_x(dat, 1'b0, d, acks[0]);
		stop_x;
	endtask : write_xfer

	// Address, then one byte from the device closed by a not-ack
	task automatic read_xfer(input logic [7:0] a, output logic [7:0] d, output logic ack);
		logic [7:0] x;
		logic n;
		start_x;
		byte_x(a, 1'b0, x, ack);
		byte_x(8'hff, 1'b0, d, n);
		stop_x;
	endtask : read_xfer
endmodule : owp_master

`default_nettype wire

/* File: sim/test_otp_wiper_i2c_programmer.sv */
`timescale 1ns/1ps
`default_nettype none

module test_otp_wiper_i2c_programmer;
	import owp_pkg::*;
	localparam int TICK = 80;
	localparam logic [7:0] WADDR = {SLAVE_ADDR_HI, 2'b10};
	localparam logic [7:0] RADDR = {SLAVE_ADDR_HI, 2'b11};
	typedef struct {logic p; logic a; logic [5:0] c;} owp_row_t;
	// Design signals
	logic        clk, srst, scl, sda_pull, sda, sda_out, sda_oe, sel_pin;
	logic        fuse_blow, seq_clk_en, vh, vl, locked, ack, block_test;
	logic [2:0]  fuse_index, acks;
	logic [5:0]  code, exp, stuck;
	logic [7:0]  fuses, rd;
	logic [63:0] taps;
	int          n_fail = 0, n_checks = 0, cycles = 0, blows = 0;
	owp_row_t    rows [6] = '{'{1'b1, 1'b1, 6'h00}, '{1'b1, 1'b1, 6'h01},
		'{1'b0, 1'b0, 6'h3f}, '{1'b1, 1'b0, 6'h15}, '{1'b0, 1'b1, 6'h15}, '{1'b1, 1'b1, 6'h2a}};

	// Open-drain data line with pull-up
	assign sda = ~(sda_pull | (sda_oe & ~sda_out));

	owp_top #(.TICK_CYCLES(TICK)) i_owp_top (.clk(clk), .srst(srst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .bus_address_select_pin(sel_pin),
		.fuse_state(fuses), .fuse_blow(fuse_blow), .fuse_index(fuse_index),
		.seq_clk_en(seq_clk_en), .resistor_ladder_setting(code), .tap_select(taps),
		.validation_bit_high(vh), .validation_bit_low(vl), .part_locked(locked));
	owp_master i_owp_master (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Fuse array with injectable faults, plus the run limit
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (fuse_blow) begin
			if (fuse_index <= LAST_DATA_IDX)
				blows <= blows + 1;
			if (!(fuse_index == FUSE_TEST_IDX && block_test) &&
				!(fuse_index <= LAST_DATA_IDX && stuck[fuse_index]))
				fuses[fuse_index] <= 1'b1;
		end
		if (cycles == 40000) begin
			n_fail++;
			finish_test;
		end
	end

	////////////////////////////////////////
	task automatic check(input logic [63:0] seen, exp_v);
		n_checks++;
		if (seen !== exp_v) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp_v);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	task automatic pwr_on;
		srst = 1'b1;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		repeat (20) @(negedge clk);
	endtask : pwr_on

	// Program a code, wait for the sequencer, read the outcome back
	task automatic prog(input logic [5:0] c, input logic [1:0] v);
		blows = 0;
		i_owp_master.write_xfer(WADDR, 8'h80, {2'b00, c}, acks);
		check(acks, 3'b111);
		check(seq_clk_en, 1'b1);
		for (int i = 0; i < 1500 && seq_clk_en !== 1'b0; i++)
			@(negedge clk);
		@(negedge clk); // Status bits settle one clock after the sequencer stops
		check({seq_clk_en, vh, vl}, {1'b0, v});
		i_owp_master.read_xfer(RADDR, rd, ack);
		check(rd, {v, c});
	endtask : prog

	////////////////////////////////////////
	initial begin
		srst = 1'b1;
		sel_pin = 1'b1;
		fuses = 8'h00;
		block_test = 1'b0;
		stuck = 6'h00;
		exp = WIPER_MIDSCALE;
		pwr_on;
		check(code, 6'h20);
		check(taps, 64'h1 << 32);
		check({vh, vl, locked, seq_clk_en}, 4'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			sel_pin = rows[i].p;
			if (rows[i].p == rows[i].a)
				exp = rows[i].c;
			i_owp_master.write_xfer({SLAVE_ADDR_HI, rows[i].a, 1'b0}, 8'h7f,
				{2'b11, rows[i].c}, acks);
			check(acks, {3{rows[i].p == rows[i].a}});
			check(code, exp);
			check(taps, 64'h1 << exp);
			i_owp_master.read_xfer({SLAVE_ADDR_HI, rows[i].p, 1'b1}, rd, ack);
			check({ack, rd}, {1'b1, 2'b00, exp});
		end
		$display("test table done");
		block_test = 1'b1;
		prog(6'h2a, VAL_SETUP_FAULT);
		check(fuses, 8'h00);
		block_test = 1'b0;
		stuck = 6'h02;
		prog(6'h2a, VAL_FATAL);
		check({blows, fuses}, {32'd3, 8'h68});
		stuck = 6'h00;
		prog(6'h2a, VAL_DONE);
		check({locked, fuses}, {1'b1, 8'hea});
		i_owp_master.write_xfer(WADDR, 8'h80, 8'h05, acks);
		check({acks, seq_clk_en, code}, {3'b111, 1'b0, 6'h2a});
		check({vh, vl}, VAL_DONE);
		$display("test program done");
		pwr_on;
		check({locked, vh, vl, code}, {3'b111, 6'h2a});
		check(taps, 64'h1 << 6'h2a);
		$display("test relock done");
		finish_test;
	end
endmodule : test_otp_wiper_i2c_programmer

`default_nettype wire
